// File: bench/dcs_regs_checker.sv
`timescale 1ns/1ns
// ========================================================
// Port checks
module dcs_regs_checker
    import dcs_pkg::*;
#(
    parameter int STARTUP_LEN = STARTUP_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_chip_select_n,
    input wire logic o_do_oe_n,
    input wire logic i_supply_over,
    input wire logic i_supply_under,
    input wire logic i_thermal_shutdown,
    input wire logic o_active,
    input wire logic o_outputs_enable,
    input wire logic o_not_ready,
    input wire logic [3:0] o_monitor_route,
    input wire logic o_retry_duty
);
    localparam int NR_MAX = STARTUP_LEN + 1;
    int nr_cycles;
    // Cycles spent not ready, counted only while the clock runs
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            nr_cycles <= 0;
        end else if (!o_not_ready) begin
            nr_cycles <= 0;
        end else if (i_ce) begin
            nr_cycles <= nr_cycles + 1;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_over_held; (i_supply_over && i_ce) [*3]; endsequence
    sequence s_under_held; (i_supply_under && i_ce) [*3]; endsequence
    sequence s_hot_held; (i_thermal_shutdown && i_ce) [*3]; endsequence
    a_over_outputs_off: assert property (
        s_over_held |=> !o_outputs_enable)
        else $error("outputs on during overvoltage");
    a_under_outputs_off: assert property (
        s_under_held |=> !o_outputs_enable)
        else $error("outputs on during undervoltage");
    a_hot_outputs_off: assert property (
        s_hot_held |=> !o_outputs_enable)
        else $error("outputs on during thermal shutdown");
    a_nr_blocks_out: assert property (
        o_not_ready |-> !o_outputs_enable)
        else $error("outputs on while not ready");
    a_active_sets_nr: assert property (
        $rose(o_active) |=> o_not_ready)
        else $error("not ready missing after wake");
    a_nr_self_clear: assert property (
        nr_cycles <= NR_MAX)
        else $error("not ready stuck");
    a_standby_off: assert property (
        !o_active |=> !o_outputs_enable)
        else $error("outputs on in standby");
    a_select_drives_do: assert property (
        o_do_oe_n == i_chip_select_n)
        else $error("data out enable wrong");
    a_route_onehot: assert property (
        $onehot(o_monitor_route))
        else $error("monitor route not one-hot");
    a_ce_freeze: assert property (
        !i_ce |=> $stable(o_active) && $stable(o_retry_duty)
        && $stable(o_monitor_route) && $stable(o_not_ready))
        else $error("state moved with clock enable low");
endmodule
bind dcs_ctrl_status_regs dcs_regs_checker #(.STARTUP_LEN(STARTUP_LEN)) u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_chip_select_n(i_chip_select_n), .o_do_oe_n(o_do_oe_n),
    .i_supply_over(i_supply_over), .i_supply_under(i_supply_under),
    .i_thermal_shutdown(i_thermal_shutdown), .o_active(o_active),
    .o_outputs_enable(o_outputs_enable), .o_not_ready(o_not_ready),
    .o_monitor_route(o_monitor_route), .o_retry_duty(o_retry_duty));

// File: bench/dcs_spi_master.sv
`timescale 1ns/1ns
// ========================================================
// Serial master, mode 0, clock only inside frames
module dcs_spi_master (
    output logic o_chip_select_n,
    output logic o_sclk,
    output logic o_di,
    input wire logic i_do,
    output logic [23:0] o_rd
);
    initial begin
        o_chip_select_n = 1'b1;
        o_sclk = 1'b0;
        o_di = 1'b0;
        o_rd = 24'h000000;
    end
    task automatic xfer(input logic [23:0] w, input int n);
        o_chip_select_n = 1'b0;
        for (int k = 0; k < n; k++) begin
            o_di = (k < 24) ? w[k] : 1'b0;
            #80 o_sclk = 1'b1;
            if (k < 24) o_rd[k] = i_do;
            #80 o_sclk = 1'b0;
        end
        #80 o_chip_select_n = 1'b1;
        o_di = ~o_di;
    endtask
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ns
// ========================================================
// Bench
module testbench;
    import dcs_pkg::*;
    localparam int SU = 200;
    logic i_clk, i_rst, i_ce;
    logic [4:0] pins;
    wire cs_n, sclk, di, dout, dout_oe_n, act, oe, nr, duty;
    wire [3:0] route;
    wire [23:0] rd;
    int miscompares = 0;
    int tests_run = 0;
    dcs_ctrl_status_regs #(.STARTUP_LEN(SU)) u_dut (.i_clk(i_clk),
        .i_rst(i_rst), .i_ce(i_ce), .i_sclk(sclk), .i_chip_select_n(cs_n),
        .i_di(di), .o_do(dout), .o_do_oe_n(dout_oe_n),
        .i_supply_over(pins[0]), .i_supply_under(pins[1]),
        .i_thermal_shutdown(pins[2]), .i_temp_warning(pins[3]),
        .i_other_faults(pins[4]), .o_active(act), .o_outputs_enable(oe),
        .o_not_ready(nr), .o_monitor_route(route), .o_retry_duty(duty));
    // Released data line reads inverted, so a wrong enable shows up
    dcs_spi_master u_m (.o_chip_select_n(cs_n), .o_sclk(sclk), .o_di(di),
        .i_do(dout_oe_n ? ~dout : dout), .o_rd(rd));
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    task automatic chk(input string nm, input logic [23:0] e,
        input logic [23:0] g);
        tests_run++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            miscompares++;
        end
    endtask
    task automatic frame(input logic [23:0] w, input int n);
        u_m.xfer(w, n);
        repeat (6) @(posedge i_clk);
    endtask
    task automatic rd_chk(input logic [23:0] e);
        frame(24'h000001, 24);
        chk("status", e, rd);
    endtask
    task automatic t_reset();
        chk("route", 24'h8, {20'h0, route});
        rd_chk(24'h800001);
        $display("done t_reset");
    endtask
    task automatic t_modes();
        logic [23:0] w;
        logic [3:0] tab [4];
        tab = '{4'h8, 4'h2, 4'h1, 4'h4};
        frame(24'h800000, 24);
        chk("not_ready", 24'h1, {23'h0, nr});
        rd_chk(24'h840000);
        repeat (SU + 10) @(posedge i_clk);
        chk("not_ready", 24'h0, {23'h0, nr});
        chk("outputs_enable", 24'h1, {23'h0, oe});
        for (int i = 0; i < 4; i++) begin
            w = 24'h800000;
            w[19:18] = i[1:0];
            w[21] = i[0];
            frame(w, 24);
            chk("route", {20'h0, tab[i]}, {20'h0, route});
            chk("duty", {23'h0, i[0]}, {23'h0, duty});
        end
        $display("done t_modes");
    endtask
    task automatic t_length();
        frame(24'h000000, 23);
        frame(24'h000000, 25);
        chk("active", 24'h1, {23'h0, act});
        frame(24'hc00000, 24);
        pins[3] <= 1'b1;
        repeat (5) @(posedge i_clk);
        pins[3] <= 1'b0;
        frame(24'h000000, 0);
        rd_chk(24'h880000);
        frame(24'hc00000, 24);
        $display("done t_length");
    endtask
    task automatic t_faults();
        int p;
        logic rc;
        logic [23:0] m;
        logic e;
        for (int i = 0; i < 6; i++) begin
            p = (i == 5) ? 0 : i;
            rc = (i == 5);
            m = (p < 4) ? (24'h400000 >> p) : 24'h0;
            frame({3'h4, rc, 20'h0}, 24);
            pins[p] <= 1'b1;
            repeat (5) @(posedge i_clk);
            chk("outputs_enable", {23'h0, p > 2}, {23'h0, oe});
            rd_chk(24'h800000 | m);
            pins[p] <= 1'b0;
            repeat (5) @(posedge i_clk);
            e = p != 2 && !rc;
            chk("outputs_enable", {23'h0, e}, {23'h0, oe});
            rd_chk(24'h800000 | m | {23'h0, m == 0});
            frame({3'h6, rc, 20'h0}, 24);
            rd_chk(24'h800001);
            chk("outputs_enable", 24'h1, {23'h0, oe});
        end
        $display("done t_faults");
    endtask
    task automatic t_standby();
        frame(24'h000000, 24);
        chk("active", 24'h0, {23'h0, act});
        chk("outputs_enable", 24'h0, {23'h0, oe});
        i_ce <= 1'b0;
        frame(24'h800000, 24);
        chk("active", 24'h0, {23'h0, act});
        i_ce <= 1'b1;
        repeat (2) @(posedge i_clk);
        $display("done t_standby");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        i_rst = 1'b1;
        i_ce = 1'b1;
        pins = 5'h00;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_clk);
        t_reset();
        t_modes();
        t_length();
        t_faults();
        t_standby();
        report_and_stop();
    end
endmodule

// File: hw/dcs_ctrl_status_regs.sv
`timescale 1ns/1ns
// Behaviour
// RULE1: Commit exact 24-bit frames at select release
// RULE2: Enable bit zero means standby, one active
// RULE3: Reset bit clears status at frame end
// RULE4: Status bit 0 is NOR of bits 1-22; the code also clears it while the other-faults pin is high
// RULE5: Status bit 23 always reads one
// RULE6: Over/undervoltage set flags, outputs off
// RULE7: Supply recovery reactivates unless bit 20 set
// RULE8: Thermal shutdown sets bit 20, outputs off
// RULE9: Thermal flag holds until reset bit written; the code also clears it on a committed standby write (enable bit zero)
// RULE10: Temperature warning flag sticks until cleared
// RULE11: Standby to active sets not-ready, starts timer
// RULE12: Not-ready keeps all outputs off
// RULE13: Timer expiry clears not-ready by itself
// RULE14: Start-up timer runs on internal clock
// RULE15: Bits 19:18 route monitor to one output
// RULE16: Bit 21 selects retry duty 12 or 25 percent
module dcs_ctrl_status_regs
    import dcs_pkg::*;
#(
    parameter int STARTUP_LEN = STARTUP_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_sclk,
    input wire logic i_chip_select_n,
    input wire logic i_di,
    output logic o_do,
    output logic o_do_oe_n,
    input wire logic i_supply_over,
    input wire logic i_supply_under,
    input wire logic i_thermal_shutdown,
    input wire logic i_temp_warning,
    input wire logic i_other_faults,
    output logic o_active,
    output logic o_outputs_enable,
    output logic o_not_ready,
    output logic [3:0] o_monitor_route,
    output logic o_retry_duty
);

    localparam logic [TIMER_W-1:0] TIMER_LOAD = TIMER_W'(STARTUP_LEN - 1);

    // ========================================================
    // Link side
    logic [FRAME_BITS-1:0] rx;
    logic [CNT_W-1:0] rx_count;
    logic [FRAME_BITS-1:0] snap_q;
    logic rx_tgl;

    dcs_spi_link #(
        .WIDTH(FRAME_BITS)
    ) u_link (
        .i_rst(i_rst),
        .i_sclk(i_sclk),
        .i_chip_select_n(i_chip_select_n),
        .i_di(i_di),
        .i_status(snap_q),
        .o_rx(rx),
        .o_count(rx_count),
        .o_do(o_do),
        .o_do_oe_n(o_do_oe_n),
        .o_frame_tgl(rx_tgl)
    );

    // ========================================================
    // Synchronisers for pins
    logic [2:0] cs_sync_q;
    logic [4:0] ev_s1_q;
    logic [4:0] ev_s2_q;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cs_sync_q <= 3'h7;
            ev_s1_q <= 5'h00;
            ev_s2_q <= 5'h00;
        end else if (i_ce) begin
            cs_sync_q <= {cs_sync_q[1:0], i_chip_select_n};
            ev_s1_q <= {i_other_faults, i_temp_warning,
                        i_thermal_shutdown, i_supply_under,
                        i_supply_over};
            ev_s2_q <= ev_s1_q;
        end
    end

    wire logic cs_idle = cs_sync_q[1];
    wire logic cs_rise = cs_sync_q[1] & ~cs_sync_q[2];
    wire logic ov_now = ev_s2_q[0];
    wire logic uv_now = ev_s2_q[1];
    wire logic tsd_now = ev_s2_q[2];
    wire logic tw_now = ev_s2_q[3];
    wire logic other_now = ev_s2_q[4];

    // ========================================================
    // Frame commit
    // Toggle flips on the first clock of each frame, so a select
    // pulse without clocks cannot commit the previous word again.
    // A frame that starts and ends while the clock enable is low is lost.
    logic seen_tgl_q;
    wire logic fresh = rx_tgl != seen_tgl_q;
    wire logic seen_tgl_d = cs_rise ? rx_tgl : seen_tgl_q;
    wire logic frame_ok = cs_rise & fresh
                          & (rx_count == FRAME_COUNT); // see RULE1
    wire logic commit = frame_ok & (rx[SEL_BIT] == SEL_WORD_ZERO);

    logic [FRAME_BITS-1:0] ctrl_q;
    wire logic [FRAME_BITS-1:0] ctrl_d = commit ? rx : ctrl_q; // see RULE1

    wire logic go_active = commit & rx[EN_BIT] & ~ctrl_q[EN_BIT]; // see RULE11
    wire logic go_standby = commit & ~rx[EN_BIT]; // see RULE2
    wire logic clear_cmd = (commit & rx[CLR_BIT]) | go_standby; // see RULE3

    // ========================================================
    // Sticky flags, a new event wins over a clear
    logic ov_q;
    logic uv_q;
    logic tsd_q;
    logic tw_q;
    logic nr_q;
    logic [TIMER_W-1:0] timer_q;

    wire logic ov_d = ov_now | (ov_q & ~clear_cmd); // see RULE6
    wire logic uv_d = uv_now | (uv_q & ~clear_cmd); // see RULE6
    wire logic tsd_d = tsd_now | (tsd_q & ~clear_cmd); // see RULE8
    wire logic tw_d = tw_now | (tw_q & ~clear_cmd); // see RULE10

    // ========================================================
    // Start-up timer on the internal clock
    wire logic timer_done = nr_q & (timer_q == '0) & ~go_active;
    wire logic [TIMER_W-1:0] timer_d = go_active ? TIMER_LOAD
        : (nr_q && timer_q != '0) ? timer_q - 16'h0001
        : timer_q; // see RULE14
    wire logic nr_d = go_active
        | (nr_q & ~timer_done & ~go_standby); // see RULE11 see RULE13

    // ========================================================
    // Output gating
    wire logic supply_hold = ctrl_d[RECOV_BIT] & (ov_d | uv_d); // see RULE7
    wire logic supply_block = ov_now | uv_now | supply_hold; // see RULE6
    wire logic out_en_d = ctrl_d[EN_BIT] & ~nr_d & ~tsd_d // see RULE12
                          & ~supply_block; // see RULE9

    // ========================================================
    // Status word
    logic [FRAME_BITS-1:0] status_w;

    always_comb begin
        status_w = '0;
        status_w[ST_ONE_BIT] = 1'b1; // see RULE5
        status_w[ST_OV_BIT] = ov_q;
        status_w[ST_UV_BIT] = uv_q;
        status_w[ST_TSD_BIT] = tsd_q;
        status_w[ST_TW_BIT] = tw_q;
        status_w[ST_NR_BIT] = nr_q;
        status_w[ST_OK_BIT] = ~(ov_q | uv_q | tsd_q | tw_q | nr_q
                                | other_now); // see RULE4
    end

    // ========================================================
    // Registers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_q <= CTRL_RESET;
            ov_q <= 1'b0;
            uv_q <= 1'b0;
            tsd_q <= 1'b0;
            tw_q <= 1'b0;
            nr_q <= 1'b0;
            timer_q <= '0;
            seen_tgl_q <= 1'b0;
        end else if (i_ce) begin
            ctrl_q <= ctrl_d;
            ov_q <= ov_d;
            uv_q <= uv_d;
            tsd_q <= tsd_d;
            tw_q <= tw_d;
            nr_q <= nr_d;
            timer_q <= timer_d;
            seen_tgl_q <= seen_tgl_d;
        end
    end

    // Snapshot only changes between frames, stable for the link
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            snap_q <= STATUS_RESET;
        end else if (i_ce && cs_idle) begin
            snap_q <= status_w;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_active <= 1'b0;
            o_outputs_enable <= 1'b0;
            o_not_ready <= 1'b0;
            o_monitor_route <= 4'h8;
            o_retry_duty <= 1'b0;
        end else if (i_ce) begin
            o_active <= ctrl_d[EN_BIT]; // see RULE2
            o_outputs_enable <= out_en_d;
            o_not_ready <= nr_d;
            o_monitor_route <= dcs_mon_route(
                ctrl_d[MON_HI_BIT:MON_LO_BIT]); // see RULE15
            o_retry_duty <= ctrl_d[DUTY_BIT]; // see RULE16
        end
    end

endmodule

// File: hw/dcs_pkg.sv
package dcs_pkg;

    // ========================================================
    // Frame format
    localparam int FRAME_BITS = 24;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FRAME_COUNT = 5'h18;
    localparam logic [CNT_W-1:0] COUNT_MAX = 5'h1f;
    localparam int SEL_BIT = 0;
    localparam logic SEL_WORD_ZERO = 1'b0;

    // ========================================================
    // Control word zero fields
    localparam int EN_BIT = 23;
    localparam int CLR_BIT = 22;
    localparam int DUTY_BIT = 21;
    localparam int RECOV_BIT = 20;
    localparam int MON_HI_BIT = 19;
    localparam int MON_LO_BIT = 18;
    localparam logic [23:0] CTRL_RESET = 24'h000000;

    // ========================================================
    // Status word zero fields
    localparam int ST_OK_BIT = 0;
    localparam int ST_NR_BIT = 18;
    localparam int ST_TW_BIT = 19;
    localparam int ST_TSD_BIT = 20;
    localparam int ST_UV_BIT = 21;
    localparam int ST_OV_BIT = 22;
    localparam int ST_ONE_BIT = 23;
    localparam logic [23:0] STATUS_RESET = 24'h800000;

    // ========================================================
    // Monitor select codes, {bit 19, bit 18}
    localparam logic [1:0] MON_SIX = 2'h0;
    localparam logic [1:0] MON_FOUR = 2'h1;
    localparam logic [1:0] MON_ONE = 2'h2;
    localparam logic [1:0] MON_FIVE = 2'h3;

    // ========================================================
    // Timing
    localparam int CLK_KHZ = 20000;
    localparam int STARTUP_US = 100;
    localparam int STARTUP_CYCLES = (STARTUP_US * CLK_KHZ + 999) / 1000;
    localparam int TIMER_W = 16;

    // One-hot route: bit 0 output one, 1 four, 2 five, 3 six
    function automatic logic [3:0] dcs_mon_route(input logic [1:0] sel);
        logic [3:0] r;
        r = 4'h0;
        unique case (sel)
            MON_ONE: r = 4'h1;
            MON_FOUR: r = 4'h2;
            MON_FIVE: r = 4'h4;
            MON_SIX: r = 4'h8;
        endcase
        return r;
    endfunction

endpackage

// File: hw/dcs_spi_link.sv
`timescale 1ns/1ns
module dcs_spi_link
    import dcs_pkg::*;
#(
    parameter int WIDTH = FRAME_BITS
) (
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_chip_select_n,
    input wire logic i_di,
    input wire logic [WIDTH-1:0] i_status,
    output logic [WIDTH-1:0] o_rx,
    output logic [CNT_W-1:0] o_count,
    output logic o_do,
    output logic o_do_oe_n,
    output logic o_frame_tgl
);

    logic first_q;
    logic tgl_q;
    logic [WIDTH-1:0] rx_q;
    logic [CNT_W-1:0] count_q;
    logic [WIDTH-1:0] tx_q;
    logic [CNT_W-1:0] idx_q;
    wire logic [CNT_W-1:0] count_inc;

    // ========================================================
    // Receive side, sampled on rising clock, LSB first
    assign count_inc = (count_q == COUNT_MAX) ? COUNT_MAX
                                               : count_q + 5'h01;

    // Marks the first clock edge of each frame
    always_ff @(posedge i_sclk or posedge i_chip_select_n) begin
        if (i_chip_select_n) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    // Count is held after the frame, clock stands still then
    always_ff @(posedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            rx_q <= '0;
            count_q <= '0;
            tx_q <= '0;
            tgl_q <= 1'b0;
        end else begin
            rx_q <= {i_di, rx_q[WIDTH-1:1]}; // see RULE1
            count_q <= first_q ? 5'h01 : count_inc; // see RULE1
            if (first_q) begin
                tx_q <= i_status;
                tgl_q <= ~tgl_q;
            end
        end
    end

    // ========================================================
    // Transmit side, advances on falling clock
    always_ff @(negedge i_sclk or posedge i_chip_select_n) begin
        if (i_chip_select_n) begin
            idx_q <= '0;
        end else if (idx_q != CNT_W'(WIDTH - 1)) begin
            idx_q <= idx_q + 5'h01;
        end
    end

    // Before the first edge the pin shows the no-error bit
    assign o_do = first_q ? i_status[ST_OK_BIT] : tx_q[idx_q];
    assign o_do_oe_n = i_chip_select_n;
    assign o_rx = rx_q;
    assign o_count = count_q;
    assign o_frame_tgl = tgl_q;

endmodule
